// ### rdd_pkg.sv
/*
  package for the ring descriptor dma scheduler: sizes, timing counts, states and carriers.
  assumes a single 200 MHz clock; a byte time is 80 ns.
*/
`default_nettype none
package rdd_pkg;
  // =====================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned BYTE_TIME_NS = 80;
  localparam int unsigned BYTE_CYC = (BYTE_TIME_NS * 1000) / CLK_PERIOD_PS; // 16 clocks
  localparam int unsigned SWITCH_BYTES = 16;  // descriptor/data switch overhead
  localparam int unsigned IND_BYTES_OVH = 20; // indication write overhead
  localparam int unsigned DESC_BYTES = 8;
  localparam int unsigned IND_BYTES = 8;
  localparam int unsigned DESC_CAP = 20;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned DESC_WORDS = DESC_BYTES / WORD_BYTES;
  localparam int unsigned IND_WORDS = IND_BYTES / WORD_BYTES;
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] SWITCH_CYC = CNT_W'(SWITCH_BYTES * BYTE_CYC);
  localparam logic [CNT_W-1:0] IND_OVH_CYC = CNT_W'(IND_BYTES_OVH * BYTE_CYC);

  // =====================================================
  // scheduler states and access kinds
  typedef enum logic [5:0] {
    RDD_IDLE = 6'h01,
    RDD_SETUP = 6'h02,
    RDD_DESC = 6'h04,
    RDD_DATA = 6'h08,
    RDD_IND = 6'h10,
    RDD_RXD = 6'h20
  } rdd_state_t;

  typedef enum logic [1:0] {
    RDD_K_NONE = 2'h0,
    RDD_K_RING = 2'h1,
    RDD_K_DATA = 2'h2
  } rdd_kind_t;

  // one word on the system bus port
  typedef struct packed {
    logic valid;
    logic write;
    logic rx;     // receive ring access
    logic [31:0] addr;
    logic [31:0] wdata;
  } rdd_bus_req_t;

  // one transmit descriptor: buffer address and length
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] len;
  } rdd_desc_t;
endpackage : rdd_pkg
`default_nettype wire

// ### rdd_desc_mem.sv
/*
  small descriptor store: one write port, one registered read port.
  assumes the caller never reads and writes the same slot in one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module rdd_desc_mem #(
  parameter int unsigned DEPTH = 20,
  parameter int unsigned WIDTH = 48,
  parameter int unsigned AW = 5
) (
  // clock
  input wire logic sys_clk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  // storage and registered read
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // rdd_desc_mem
`default_nettype wire

// ### rdd_sched.sv
/*
  ring descriptor dma scheduler: fetches transmit descriptors in bursts, moves frame
  data, fetches receive descriptors and writes receive indications over one port.
  assumes a word-wide bus port with a one-cycle ack; the mac side is a byte stream.
*/
// What this block does
// - hold up to twenty transmit descriptors internally before data moves
// - transmit data transfer wins the port over descriptor fetching
// - sixteen byte times of setup on every descriptor/data switch
// - each fetched descriptor is exactly eight bytes
// - each written frame indication is eight bytes
// - short frames: load twenty descriptors, move twenty frames, repeat
// - one switch overhead per burst of up to twenty descriptor fetches
// - receive descriptors fetched only once the receive ring is ready
// - receive indications written singly or grouped as priorities allow
// - one indication costs twenty byte times plus its eight bytes
`timescale 1ns/1ps
`default_nettype none
module rdd_sched
  import rdd_pkg::*;
#(
  parameter int unsigned DCAP = DESC_CAP,
  parameter int unsigned IND_MAX = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // ring control
  input wire logic tx_ring_ready,
  input wire logic [31:0] tx_ring_base,
  input wire logic rx_ring_ready,
  input wire logic [31:0] rx_ring_base,
  input wire logic [15:0] tx_watermark,
  // system bus port
  output rdd_bus_req_t bus_req,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata,
  // receive indications from the mac side
  input wire logic ind_valid,
  input wire logic [63:0] ind_data,
  output logic ind_ready,
  // transmit bytes toward the mac
  output logic tx_valid,
  output logic [7:0] tx_byte,
  output logic tx_last,
  input wire logic tx_ready,
  // status
  output logic [4:0] desc_count,
  output logic rx_desc_loaded,
  output rdd_kind_t port_kind
);
  localparam int unsigned AW = 5;

  // =====================================================
  // state record
  typedef struct packed {
    rdd_state_t st;
    rdd_state_t after;      // state taken after setup
    rdd_kind_t kind;        // kind of the last access
    logic [CNT_W-1:0] cnt;  // setup countdown
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] fill;
    logic [AW:0] burst;     // descriptors fetched this burst
    logic word;             // word within an 8-byte unit
    logic [31:0] w0;
    logic [31:0] tx_ptr;
    logic [31:0] rx_ptr;
    logic rx_loaded;
    logic [3:0] ind_n;      // indications written in this group
    logic [63:0] ind_buf;
    logic [15:0] dlen;      // bytes left of current frame
    logic [31:0] daddr;
    logic [1:0] bsel;
    logic [31:0] dword;
    logic have;             // dword holds data
    logic [15:0] held;      // release gate: min of flen and watermark after first word
    logic [15:0] flen;
    logic tv;
    logic [7:0] tb;
    logic tl;
    rdd_bus_req_t req;
  } rdd_reg_t;

  rdd_reg_t q_r, q_nxt;
  rdd_desc_t rd_desc;
  logic [47:0] rd_raw;
  logic mem_we;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DCAP - 1)) ? '0 : p + AW'(1);
  endfunction

  assign rd_desc = rd_raw;
  assign mem_we = (q_r.st == RDD_DESC) && bus_ack && q_r.word;

  rdd_desc_mem #(.DEPTH(DCAP), .WIDTH(48), .AW(AW)) u_mem (
    .sys_clk(sys_clk),
    .wr_en(mem_we),
    .wr_addr(q_r.wp),
    .wr_data({q_r.w0, bus_rdata[15:0]}),
    .rd_addr(q_r.rp),
    .rd_data(rd_raw)
  );

  // =====================================================
  // next-state logic
  always_comb begin
    logic want_data;
    logic want_desc;
    logic byte_out;
    want_data = (q_r.fill != '0) || (q_r.dlen != '0);
    want_desc = tx_ring_ready && (q_r.fill == '0) && (q_r.dlen == '0);
    byte_out = q_r.tv && tx_ready;
    q_nxt = q_r;
    q_nxt.req.valid = 1'b0;
    ind_ready = 1'b0;
    if (byte_out) begin
      q_nxt.tv = 1'b0;
    end
    case (q_r.st)
      RDD_IDLE: begin
        q_nxt.ind_n = '0;
        if (want_data) begin
          q_nxt.after = RDD_DATA;
          q_nxt.st = (q_r.kind == RDD_K_DATA) ? RDD_DATA : RDD_SETUP;
          q_nxt.cnt = SWITCH_CYC;
        end else if (ind_valid && rx_ring_ready) begin // indications only into a ready ring
          q_nxt.ind_buf = ind_data;
          ind_ready = 1'b1;
          q_nxt.after = RDD_IND;
          q_nxt.st = RDD_SETUP;
          q_nxt.cnt = IND_OVH_CYC;
        end else if (rx_ring_ready && !q_r.rx_loaded) begin
          q_nxt.after = RDD_RXD;
          q_nxt.st = (q_r.kind == RDD_K_RING) ? RDD_RXD : RDD_SETUP;
          q_nxt.cnt = SWITCH_CYC;
        end else if (want_desc) begin
          q_nxt.burst = '0;
          q_nxt.after = RDD_DESC;
          q_nxt.st = (q_r.kind == RDD_K_RING) ? RDD_DESC : RDD_SETUP;
          q_nxt.cnt = SWITCH_CYC;
        end
      end
      RDD_SETUP: begin
        if (q_r.cnt <= CNT_W'(1)) begin
          q_nxt.st = q_r.after;
        end else begin
          q_nxt.cnt = q_r.cnt - CNT_W'(1);
        end
      end
      RDD_DESC: begin
        q_nxt.kind = RDD_K_RING;
        q_nxt.req = '{valid: 1'b1, write: 1'b0, rx: 1'b0,
                      addr: q_r.tx_ptr + {29'h0, q_r.word, 2'b00}, wdata: '0};
        if (bus_ack) begin
          q_nxt.req.valid = 1'b0;
          q_nxt.word = ~q_r.word;
          if (!q_r.word) begin
            q_nxt.w0 = bus_rdata;
          end else begin
            q_nxt.tx_ptr = q_r.tx_ptr + 32'(DESC_BYTES);
            q_nxt.wp = wrap_inc(q_r.wp);
            q_nxt.fill = q_r.fill + (AW+1)'(1);
            q_nxt.burst = q_r.burst + (AW+1)'(1);
            if (q_r.fill + (AW+1)'(1) == (AW+1)'(DCAP) || !tx_ring_ready) begin
              q_nxt.st = RDD_IDLE;
            end
          end
        end
      end
      RDD_DATA: begin
        q_nxt.kind = RDD_K_DATA;
        if (q_r.dlen == '0 && !q_r.have) begin
          if (q_r.fill != '0 && !q_r.tv) begin
            // load next descriptor (read data registered from rp)
            q_nxt.daddr = rd_desc.addr;
            q_nxt.dlen = rd_desc.len;
            q_nxt.flen = rd_desc.len;
            q_nxt.held = '0;
            q_nxt.rp = wrap_inc(q_r.rp);
            q_nxt.fill = q_r.fill - (AW+1)'(1);
          end else if (q_r.fill == '0 && !q_r.tv) begin
            q_nxt.st = RDD_IDLE;
          end
        end else if (!q_r.have) begin
          q_nxt.req = '{valid: 1'b1, write: 1'b0, rx: 1'b0, addr: q_r.daddr, wdata: '0};
          if (bus_ack) begin
            q_nxt.req.valid = 1'b0;
            q_nxt.dword = bus_rdata;
            q_nxt.have = 1'b1;
            q_nxt.bsel = '0;
            q_nxt.daddr = q_r.daddr + 32'(WORD_BYTES);
          end
        end else if (!q_r.tv || byte_out) begin
          // release bytes once held reaches frame length or watermark; held is set there after one word
          if (q_r.held >= tx_watermark || q_r.held >= q_r.flen || q_r.held != '0) begin
            q_nxt.tv = 1'b1;
            q_nxt.tb = q_r.dword[8*q_r.bsel +: 8];
            q_nxt.tl = (q_r.dlen == 16'h0001);
            q_nxt.dlen = q_r.dlen - 16'h0001;
            q_nxt.bsel = q_r.bsel + 2'h1;
            if (q_r.bsel == 2'h3 || q_r.dlen == 16'h0001) begin
              q_nxt.have = 1'b0;
            end
          end else begin
            q_nxt.held = (q_r.flen < tx_watermark) ? q_r.flen : tx_watermark;
          end
        end
      end
      RDD_IND: begin
        q_nxt.kind = RDD_K_RING;
        q_nxt.req = '{valid: 1'b1, write: 1'b1, rx: 1'b1,
                      addr: q_r.rx_ptr + {29'h0, q_r.word, 2'b00},
                      wdata: q_r.word ? q_r.ind_buf[31:0] : q_r.ind_buf[63:32]};
        if (bus_ack) begin
          q_nxt.req.valid = 1'b0;
          q_nxt.word = ~q_r.word;
          if (q_r.word) begin
            q_nxt.rx_ptr = q_r.rx_ptr + 32'(IND_BYTES);
            q_nxt.ind_n = q_r.ind_n + 4'h1;
            // group further waiting indications unless data waits
            if (ind_valid && !want_data && q_r.ind_n + 4'h1 < 4'(IND_MAX)) begin
              q_nxt.ind_buf = ind_data;
              ind_ready = 1'b1;
            end else begin
              q_nxt.st = RDD_IDLE;
            end
          end
        end
      end
      RDD_RXD: begin
        q_nxt.kind = RDD_K_RING;
        q_nxt.req = '{valid: 1'b1, write: 1'b0, rx: 1'b1,
                      addr: q_r.rx_ptr + {29'h0, q_r.word, 2'b00}, wdata: '0};
        if (bus_ack) begin
          q_nxt.req.valid = 1'b0;
          q_nxt.word = ~q_r.word;
          if (q_r.word) begin
            q_nxt.rx_loaded = 1'b1;
            q_nxt.st = RDD_IDLE;
          end
        end
      end
      default: begin
        q_nxt.st = RDD_IDLE;
      end
    endcase
    if (!tx_ring_ready && q_r.st == RDD_IDLE && q_r.fill == '0) begin
      q_nxt.tx_ptr = tx_ring_base;
    end
    if (!rx_ring_ready) begin
      q_nxt.rx_ptr = rx_ring_base;
      q_nxt.rx_loaded = 1'b0;
    end
  end

  // =====================================================
  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q_r <= '{st: RDD_IDLE, after: RDD_IDLE, kind: RDD_K_NONE, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs
  assign bus_req = q_r.req;
  assign tx_valid = q_r.tv;
  assign tx_byte = q_r.tb;
  assign tx_last = q_r.tl;
  assign desc_count = q_r.fill[4:0];
  assign rx_desc_loaded = q_r.rx_loaded;
  assign port_kind = q_r.kind;
endmodule // rdd_sched
`default_nettype wire

// ### rdd_sched_sva.sv
/*
  port checker for rdd_sched.
  assumes the tx ring lies within 4 KiB above its base.
*/
`timescale 1ns/1ps
`default_nettype none
module rdd_sched_sva
  import rdd_pkg::*;
#(
  parameter int unsigned DCAP = 20,
  parameter int unsigned IND_MAX = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // watched ports
  input wire logic rx_ring_ready,
  input wire logic [31:0] tx_ring_base,
  input wire rdd_bus_req_t bus_req,
  input wire logic bus_ack,
  input wire logic ind_valid,
  input wire logic ind_ready,
  input wire logic [4:0] desc_count,
  input wire rdd_kind_t port_kind
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic drd, wrd, ring, odd_r, wodd_r;
  logic [15:0] gap_r;
  logic [31:0] wa_r;
  // =========================================
  // request class, idle gap, word pairing
  assign drd = bus_req.valid && !bus_req.write && !bus_req.rx && (bus_req.addr - tx_ring_base) < 32'h1000;
  assign wrd = bus_req.valid && bus_req.write;
  assign ring = drd || bus_req.write || bus_req.rx;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_r <= 16'h0;
      odd_r <= 1'b0;
      wodd_r <= 1'b0;
      wa_r <= 32'h0;
    end else begin
      gap_r <= bus_req.valid ? 16'h0 : gap_r + {15'h0, gap_r != 16'hffff};
      odd_r <= odd_r ^ (drd && bus_ack);
      wodd_r <= wodd_r ^ (wrd && bus_ack);
      if (wrd && bus_ack) wa_r <= bus_req.addr;
    end
  end
  // =========================================
  // properties
  property p_full; desc_count == 5'(DCAP) |-> !drd; endproperty
  a_full: assert property (p_full) else $error("fetch past capacity");
  property p_prio; $rose(drd) && port_kind != RDD_K_RING |-> desc_count == 5'h00; endproperty
  a_prio: assert property (p_prio) else $error("fetch with data pending");
  property p_setup;
    $rose(bus_req.valid) && port_kind != RDD_K_NONE && ring != (port_kind == RDD_K_RING) |-> gap_r >= SWITCH_CYC - 16'h8;
  endproperty
  a_setup: assert property (p_setup) else $error("switch setup too short");
  property p_burst; $rose(drd) && port_kind == RDD_K_RING && desc_count != 5'h00 |-> gap_r < 16'h10; endproperty
  a_burst: assert property (p_burst) else $error("setup inside burst");
  property p_cnt; drd && bus_ack && odd_r |=> desc_count == $past(desc_count) + 5'h01; endproperty
  a_cnt: assert property (p_cnt) else $error("two words not one descriptor");
  property p_wpair; wrd && wodd_r |-> bus_req.addr == wa_r + 32'h4; endproperty
  a_wpair: assert property (p_wpair) else $error("indication words apart");
  property p_rx; bus_req.valid && bus_req.rx |-> rx_ring_ready; endproperty
  a_rx: assert property (p_rx) else $error("rx access while not ready");
  property p_ind; ind_valid && ind_ready |-> ##[1:1000] wrd; endproperty
  a_ind: assert property (p_ind) else $error("indication never written");
  c_full: cover property (desc_count == 5'(DCAP));
  c_ind: cover property (wrd && bus_ack);
  c_rx: cover property (bus_req.rx && bus_ack);
endmodule // rdd_sched_sva
bind rdd_sched rdd_sched_sva #(.DCAP(DCAP), .IND_MAX(IND_MAX)) u_sva (.sys_clk, .arst_n, .rx_ring_ready,
  .tx_ring_base, .bus_req, .bus_ack, .ind_valid, .ind_ready, .desc_count, .port_kind);
`default_nettype wire

// ### rdd_mem_model.sv
/*
  memory on the far side of the bus port.
  assumes a request holds until acked.
*/
`timescale 1ns/1ps
`default_nettype none
module rdd_mem_model
  import rdd_pkg::*;
#(
  parameter logic [31:0] TXB = 32'h0000_1000,
  parameter logic [31:0] BUF = 32'h0010_0000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // pacing: slow adds wait cycles
  input wire logic slow,
  // bus port
  input wire rdd_bus_req_t bus_req,
  output logic bus_ack,
  output logic [31:0] bus_rdata
);
  logic [31:0] off;
  logic [1:0] wt_r;
  assign off = bus_req.addr - TXB;
  // =========================================
  // one port serves descriptors, data, indications
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_ack <= 1'b0;
      bus_rdata <= 32'h0;
      wt_r <= 2'h0;
    end else if (bus_req.valid && !bus_ack && (!slow || wt_r == 2'h3)) begin
      bus_ack <= 1'b1;
      wt_r <= 2'h0;
      // descriptor: buffer address then length 4
      if (off < 32'h1000) bus_rdata <= off[2] ? 32'h4 : BUF + {off[30:0], 1'b0};
      else bus_rdata <= bus_req.addr ^ 32'h5a5a_0000;
    end else begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata; // no stale data off the ack
      wt_r <= bus_req.valid ? wt_r + 2'h1 : 2'h0;
    end
  end
endmodule // rdd_mem_model
`default_nettype wire

// ### rdd_sched_test.sv
/*
  self-checking bench for rdd_sched.
  assumes rdd_mem_model on the bus port.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module rdd_sched_test
  import rdd_pkg::*;
;
  localparam logic [31:0] TXB = 32'h0000_1000;
  localparam logic [31:0] BUF = 32'h0010_0000;
  logic sys_clk = 0, arst_n = 0, tx_ring_ready = 0, rx_ring_ready = 0, slow = 0, ind_valid = 0, tx_ready = 0;
  logic bus_ack, ind_ready, tx_valid, tx_last, rx_desc_loaded;
  logic [15:0] tx_watermark = 16'h0010; // above largest frame
  logic [31:0] bus_rdata;
  logic [31:0] wq[$];
  logic [63:0] ind_data = 64'h0;
  logic [7:0] tx_byte;
  logic [4:0] desc_count;
  rdd_bus_req_t bus_req;
  rdd_kind_t port_kind;
  int n_mismatch = 0, check_count = 0, n_rd = 0, n_rx = 0, cyc = 0, t_req = 0;
  rdd_sched DUT (.sys_clk, .arst_n, .tx_ring_ready, .tx_ring_base(TXB), .rx_ring_ready,
    .rx_ring_base(32'h0000_2000), .tx_watermark, .bus_req, .bus_ack, .bus_rdata, .ind_valid, .ind_data,
    .ind_ready, .tx_valid, .tx_byte, .tx_last, .tx_ready, .desc_count, .rx_desc_loaded, .port_kind);
  rdd_mem_model #(.TXB(TXB), .BUF(BUF)) u_mem (.sys_clk, .arst_n, .slow, .bus_req, .bus_ack, .bus_rdata);
  // =========================================
  // clock and finished-word monitor
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (arst_n && bus_req.valid && bus_ack) begin
      if (bus_req.write) wq.push_back(bus_req.wdata);
      else if (bus_req.rx) n_rx++;
      else n_rd++;
      if (t_req == 0) t_req = cyc;
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // take 20 frames with the mac stalling every other cycle
  task automatic drain(input int f0);
    logic [31:0] w;
    int j;
    j = 0;
    for (int k = 0; k < 4000 && j < 80; k++) begin
      @(negedge sys_clk);
      tx_ready = k[0];
      #1;
      if (tx_valid && tx_ready) begin
        w = (BUF + 32'((f0 + j / 4) * 16)) ^ 32'h5a5a_0000;
        `CHK("tx_byte", w[8 * (j % 4) +: 8], tx_byte)
        `CHK("tx_last", j % 4 == 3, tx_last)
        j++;
      end
    end
    @(negedge sys_clk);
    tx_ready = 0;
  endtask
  task automatic wait_full();
    for (int k = 0; k < 3000 && desc_count !== 5'(DESC_CAP); k++) @(negedge sys_clk);
  endtask
  task automatic send(input logic [63:0] d);
    ind_data = d;
    ind_valid = 1;
    #1;
    for (int k = 0; k < 2000 && ind_ready !== 1'b1; k++) begin
      @(negedge sys_clk);
      #1;
    end
    @(negedge sys_clk);
  endtask
  // =========================================
  // scenarios
  task automatic t_idle();
    repeat (300) @(negedge sys_clk);
    `CHK("idle_words", 0, n_rd + n_rx)
    $display("test idle done");
  endtask
  task automatic t_tx();
    int c0;
    t_req = 0;
    c0 = cyc;
    tx_ring_ready = 1;
    wait_full();
    `CHK("desc_count", 5'(DESC_CAP), desc_count)
    `CHK("desc_words", 2 * DESC_CAP, n_rd)
    `CHK("setup", 1'b1, t_req - c0 >= SWITCH_CYC)
    drain(0);
    wait_full();
    `CHK("refill", 5'(DESC_CAP), desc_count)
    tx_ring_ready = 0;
    drain(DESC_CAP);
    `CHK("tx_words", 6 * DESC_CAP, n_rd)
    $display("test tx done");
  endtask
  task automatic t_rx();
    int t0;
    logic [31:0] ex[6];
    ex = '{32'h1122_3344, 32'h5566_7788, 32'haaaa_bbbb, 32'hcccc_dddd, 32'h0123_4567, 32'h89ab_cdef};
    slow = 1;
    rx_ring_ready = 1;
    for (int k = 0; k < 2000 && rx_desc_loaded !== 1'b1; k++) @(negedge sys_clk);
    `CHK("rx_desc", 1'b1, rx_desc_loaded && n_rx > 0)
    send({ex[0], ex[1]});
    ind_valid = 0;
    t0 = cyc;
    for (int k = 0; k < 2000 && wq.size() < 2; k++) @(negedge sys_clk);
    `CHK("ind_delay", 1'b1, cyc - t0 >= IND_OVH_CYC)
    send({ex[2], ex[3]});
    send({ex[4], ex[5]});
    ind_valid = 0;
    for (int k = 0; k < 3000 && wq.size() < 6; k++) @(negedge sys_clk);
    for (int i = 0; i < 6; i++) `CHK("ind_word", ex[i], wq[i])
    $display("test rx done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1;
    t_idle();
    t_tx();
    t_rx();
    conclude();
  end
  // watchdog well past the few thousand cycles expected
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule // rdd_sched_test
`default_nettype wire
